// ---- common/fsp_consts.svh ----
// Constants for the flash self-programming sequencer: offsets, fields, codes, timing.
// Included by the package users; holds definitions only.
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave
`define FSP_OFS_CTRL 8'h00
`define FSP_OFS_KEY 8'h04
`define FSP_OFS_ADRL 8'h08
`define FSP_OFS_ADRH 8'h0C
`define FSP_OFS_SRC 8'h10
`define FSP_OFS_LAT0 8'h14
`define FSP_OFS_LAT1 8'h18

// Control register field positions
`define FSP_BIT_WR 15
`define FSP_BIT_WREN 14
`define FSP_BIT_SEQUENCE_ERROR_FLAG 13
`define FSP_BIT_SWPDONE 11
`define FSP_BIT_P2 10
`define FSP_BIT_ROW_DATA_PACKING_BIT 9
`define FSP_BIT_ROW_UNDERRUN_ERROR_FLAG 8

// Unlock key values
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'hAA

// Operation select codes
`define FSP_OP_DWORD 4'h1
`define FSP_OP_ROW 4'h2
`define FSP_OP_PAGE 4'h3
`define FSP_OP_PART 4'h4

// Array geometry in program address units (two units per instruction)
`define FSP_ROW_MASK 24'hFFFF80
`define FSP_PAGE_MASK 24'hFFFC00
`define FSP_DWORD_MASK 24'hFFFFFC
`define FSP_DWORD_STEP 24'h000004
`define FSP_PART_BIT 22
`define FSP_LAST_PAIR 5'h1F
`define FSP_LAST_WORD_UNPACKED 2'h3
`define FSP_LAST_WORD_PACKED 2'h2
`define FSP_RAM_STEP 16'h0002

// RAM fetch wait before a row is declared underrun
`define FSP_CLK_NS 8
`define FSP_FETCH_WAIT_NS 64
`define FSP_FETCH_WAIT_CYC ((`FSP_FETCH_WAIT_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// ---- common/fsp_pkg.sv ----
// Types of the flash self-programming sequencer.
// Assumes fsp_consts.svh is compiled alongside for the numeric constants.
package fsp_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_FETCH = 3'h2,
    ST_FLASH = 3'h4
  } fsp_state_type;

  typedef enum logic [1:0]
  {
    CMD_PROG = 2'h0,
    CMD_ERASE_PAGE = 2'h1,
    CMD_ERASE_PART = 2'h2
  } fsp_cmd_type;

  typedef enum logic [1:0]
  {
    KEY_NONE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h2
  } fsp_key_type;

  typedef struct packed
  {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic wr;
    logic wren;
    logic sequence_error_flag;
    logic swp_done;
    logic p2_act;
    logic row_data_packing_bit;
    logic row_underrun_error_flag;
    logic [3:0] op;
    logic [23:0] adr;
    logic [15:0] src;
    logic [23:0] lat0;
    logic [23:0] lat1;
    fsp_key_type key;
    fsp_state_type fsm;
    fsp_cmd_type cmd;
    logic stall;
    logic done;
    logic flash_req;
    logic [23:0] flash_addr;
    logic [47:0] flash_wdata;
    logic ram_req;
    logic [15:0] ram_addr;
    logic [1:0] word_idx;
    logic [4:0] pair_idx;
    logic [3:0] wait_cnt;
    logic [63:0] words;
    logic boot_done;
  } fsp_regs_type;

endpackage

// ---- src/fsp_sequencer.sv ----
// Flash self-programming sequencer: AHB-Lite registers, key unlock, row/double-word
// programming, page and partition erase, boot partition choice and soft swap.
// Assumes config inputs, flash array and RAM port all run on hclk.
`timescale 1ns/1ns
`include "fsp_consts.svh"

module fsp_sequencer
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration
  input wire logic dual_mode,
  input wire logic protect_mode,
  input wire logic [23:0] boot_cfg_p1,
  input wire logic [23:0] boot_cfg_p2,
  // Processor side
  input wire logic swap_exec,
  output logic cpu_stall,
  output logic nvm_done,
  output logic part2_live,
  // Flash array
  output logic flash_req,
  output logic [1:0] flash_cmd,
  output logic [23:0] flash_addr,
  output logic [47:0] flash_wdata,
  input wire logic flash_ack,
  // RAM fetch port
  output logic ram_req,
  output logic [15:0] ram_addr,
  input wire logic [15:0] ram_rdata,
  input wire logic ram_valid
);

  fsp_pkg::fsp_regs_type s_q;
  fsp_pkg::fsp_regs_type s_d;
  logic addr_phase;
  logic start_try;
  logic start_ok;
  logic to_p1;
  logic [23:0] phys_adr;
  logic [63:0] words_new;
  logic [23:0] instr1;
  logic [23:0] instr2;
  logic [1:0] last_word;
  logic v1;
  logic v2;

  // Boot order validity and partition mapping
  assign v1 = boot_cfg_p1[23:12] == ~boot_cfg_p1[11:0];
  assign v2 = boot_cfg_p2[23:12] == ~boot_cfg_p2[11:0];
  assign phys_adr = {s_q.adr[23], s_q.adr[`FSP_PART_BIT] ^ s_q.p2_act, s_q.adr[21:0]};
  assign last_word = s_q.row_data_packing_bit ? `FSP_LAST_WORD_PACKED : `FSP_LAST_WORD_UNPACKED;
  assign addr_phase = hsel && hready && htrans[1];

  // Next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    start_try = 1'b0;
    start_ok = 1'b0;
    to_p1 = 1'b0;
    words_new = s_q.words;
    words_new[16 * s_q.word_idx +: 16] = ram_rdata;
    instr1 = {words_new[23:16], words_new[15:0]};
    // Packed form puts the second top byte in the upper half of word 1
    if (s_q.row_data_packing_bit)
    begin
      instr2 = {words_new[31:24], words_new[47:32]};
    end
    else
    begin
      instr2 = {words_new[55:48], words_new[47:32]};
    end

    // Address phase: capture write, answer reads next cycle
    s_d.dph_wr = addr_phase && hwrite;
    s_d.dph_addr = haddr[7:0];
    s_d.hrdata = 32'h0000_0000;
    if (addr_phase && !hwrite)
    begin
      case (haddr[7:0])
        `FSP_OFS_CTRL:
          s_d.hrdata = {16'h0000, s_q.wr, s_q.wren, s_q.sequence_error_flag, 1'b0, s_q.swp_done,
                        s_q.p2_act, s_q.row_data_packing_bit, s_q.row_underrun_error_flag, 4'h0, s_q.op};
        `FSP_OFS_ADRL: s_d.hrdata = {16'h0000, s_q.adr[15:0]};
        `FSP_OFS_ADRH: s_d.hrdata = {24'h00_0000, s_q.adr[23:16]};
        `FSP_OFS_SRC: s_d.hrdata = {16'h0000, s_q.src};
        `FSP_OFS_LAT0: s_d.hrdata = {8'h00, s_q.lat0};
        `FSP_OFS_LAT1: s_d.hrdata = {8'h00, s_q.lat1};
        default: s_d.hrdata = 32'h0000_0000;
      endcase
    end

    // Data phase writes
    if (s_q.dph_wr)
    begin
      // Any write other than to the key drops a partial or full unlock
      if (s_q.dph_addr != `FSP_OFS_KEY)
      begin
        s_d.key = fsp_pkg::KEY_NONE;
      end
      case (s_q.dph_addr)
        `FSP_OFS_CTRL:
        begin
          if (!hwdata[`FSP_BIT_SWPDONE])
          begin
            s_d.swp_done = 1'b0;
          end
          if (s_q.fsm == fsp_pkg::ST_IDLE)
          begin
            s_d.wren = hwdata[`FSP_BIT_WREN];
            s_d.row_data_packing_bit = hwdata[`FSP_BIT_ROW_DATA_PACKING_BIT];
            s_d.op = hwdata[3:0];
            if (!hwdata[`FSP_BIT_SEQUENCE_ERROR_FLAG])
            begin
              s_d.sequence_error_flag = 1'b0;
            end
            if (!hwdata[`FSP_BIT_ROW_UNDERRUN_ERROR_FLAG])
            begin
              s_d.row_underrun_error_flag = 1'b0;
            end
            start_try = hwdata[`FSP_BIT_WR];
          end
        end
        `FSP_OFS_KEY:
        begin
          if (hwdata[7:0] == `FSP_KEY_FIRST)
          begin
            s_d.key = fsp_pkg::KEY_HALF;
          end
          else if (s_q.key == fsp_pkg::KEY_HALF && hwdata[7:0] == `FSP_KEY_SECOND)
          begin
            s_d.key = fsp_pkg::KEY_OPEN;
          end
          else
          begin
            s_d.key = fsp_pkg::KEY_NONE;
          end
        end
        `FSP_OFS_ADRL:
          if (s_q.fsm == fsp_pkg::ST_IDLE)
          begin
            s_d.adr[15:0] = hwdata[15:0];
          end
        `FSP_OFS_ADRH:
          if (s_q.fsm == fsp_pkg::ST_IDLE)
          begin
            s_d.adr[23:16] = hwdata[7:0];
          end
        `FSP_OFS_SRC:
          if (s_q.fsm == fsp_pkg::ST_IDLE)
          begin
            s_d.src = hwdata[15:0];
          end
        `FSP_OFS_LAT0: s_d.lat0 = hwdata[23:0];
        `FSP_OFS_LAT1: s_d.lat1 = hwdata[23:0];
        default: s_d.key = fsp_pkg::KEY_NONE;
      endcase
    end

    // Start request: check unlock, enable, code and protection
    if (start_try)
    begin
      if (hwdata[3:0] == `FSP_OP_PART)
      begin
        to_p1 = s_q.p2_act;
      end
      else
      begin
        to_p1 = !phys_adr[`FSP_PART_BIT];
      end
      start_ok = s_q.key == fsp_pkg::KEY_OPEN && hwdata[`FSP_BIT_WREN] &&
                 hwdata[3:0] >= `FSP_OP_DWORD && hwdata[3:0] <= `FSP_OP_PART &&
                 !(protect_mode && dual_mode && to_p1) &&
                 !(hwdata[3:0] == `FSP_OP_PART && !dual_mode);
      s_d.key = fsp_pkg::KEY_NONE;
      if (!start_ok)
      begin
        s_d.sequence_error_flag = 1'b1;
      end
      else
      begin
        s_d.wr = 1'b1;
        s_d.flash_addr = phys_adr;
        // In dual mode, inactive-side work leaves the processor running
        s_d.stall = !dual_mode ||
                    (hwdata[3:0] != `FSP_OP_PART && !s_q.adr[`FSP_PART_BIT]);
        case (hwdata[3:0])
          `FSP_OP_DWORD:
          begin
            s_d.cmd = fsp_pkg::CMD_PROG;
            s_d.flash_addr = phys_adr & `FSP_DWORD_MASK;
            s_d.flash_wdata = {s_q.lat1, s_q.lat0};
            s_d.flash_req = 1'b1;
            s_d.fsm = fsp_pkg::ST_FLASH;
          end
          `FSP_OP_ROW:
          begin
            s_d.adr = s_q.adr & `FSP_ROW_MASK;
            s_d.ram_addr = s_q.src;
            s_d.ram_req = 1'b1;
            s_d.word_idx = 2'h0;
            s_d.pair_idx = 5'h00;
            s_d.wait_cnt = 4'h0;
            s_d.fsm = fsp_pkg::ST_FETCH;
          end
          `FSP_OP_PAGE:
          begin
            s_d.cmd = fsp_pkg::CMD_ERASE_PAGE;
            s_d.flash_addr = phys_adr & `FSP_PAGE_MASK;
            s_d.flash_req = 1'b1;
            s_d.fsm = fsp_pkg::ST_FLASH;
          end
          default:
          begin
            s_d.cmd = fsp_pkg::CMD_ERASE_PART;
            s_d.flash_addr = 24'h00_0000;
            s_d.flash_addr[`FSP_PART_BIT] = !s_q.p2_act;
            s_d.flash_req = 1'b1;
            s_d.fsm = fsp_pkg::ST_FLASH;
          end
        endcase
      end
    end

    // Sequencer
    case (s_q.fsm)
      fsp_pkg::ST_IDLE:
      begin
      end
      fsp_pkg::ST_FETCH:
      begin
        if (ram_valid)
        begin
          s_d.words = words_new;
          s_d.wait_cnt = 4'h0;
          s_d.src = s_q.src + `FSP_RAM_STEP;
          s_d.ram_addr = s_q.ram_addr + `FSP_RAM_STEP;
          if (s_q.word_idx == last_word)
          begin
            s_d.ram_req = 1'b0;
            s_d.cmd = fsp_pkg::CMD_PROG;
            s_d.flash_addr = phys_adr;
            s_d.flash_wdata = {instr2, instr1};
            s_d.flash_req = 1'b1;
            s_d.fsm = fsp_pkg::ST_FLASH;
          end
          else
          begin
            s_d.word_idx = s_q.word_idx + 2'h1;
          end
        end
        else if (s_q.wait_cnt == 4'(`FSP_FETCH_WAIT_CYC))
        begin
          // Data did not arrive in time: terminate the row
          s_d.row_underrun_error_flag = 1'b1;
          s_d.ram_req = 1'b0;
          s_d.wr = 1'b0;
          s_d.stall = 1'b0;
          s_d.fsm = fsp_pkg::ST_IDLE;
        end
        else
        begin
          s_d.wait_cnt = s_q.wait_cnt + 4'h1;
        end
      end
      fsp_pkg::ST_FLASH:
      begin
        if (flash_ack)
        begin
          s_d.flash_req = 1'b0;
          if (s_q.op == `FSP_OP_ROW && s_q.pair_idx != `FSP_LAST_PAIR)
          begin
            // Next instruction pair of the row
            s_d.adr = s_q.adr + `FSP_DWORD_STEP;
            s_d.pair_idx = s_q.pair_idx + 5'h01;
            s_d.word_idx = 2'h0;
            s_d.ram_req = 1'b1;
            s_d.fsm = fsp_pkg::ST_FETCH;
          end
          else
          begin
            if (s_q.op == `FSP_OP_ROW)
            begin
              s_d.adr = s_q.adr + `FSP_DWORD_STEP;
            end
            s_d.wr = 1'b0;
            s_d.stall = 1'b0;
            s_d.done = 1'b1;
            s_d.fsm = fsp_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        s_d.fsm = fsp_pkg::ST_IDLE;
        s_d.flash_req = 1'b0;
        s_d.ram_req = 1'b0;
        s_d.wr = 1'b0;
        s_d.stall = 1'b0;
      end
    endcase

    // Soft swap; its flag set wins over a clear in the same cycle
    if (swap_exec && dual_mode)
    begin
      if (s_q.key == fsp_pkg::KEY_OPEN && s_q.fsm == fsp_pkg::ST_IDLE)
      begin
        s_d.p2_act = !s_q.p2_act;
        s_d.swp_done = 1'b1;
      end
      s_d.key = fsp_pkg::KEY_NONE;
    end

    // Boot partition choice on the first cycle after reset
    if (!s_q.boot_done)
    begin
      s_d.boot_done = 1'b1;
      s_d.p2_act = dual_mode && v2 &&
                   (!v1 || boot_cfg_p2[11:0] < boot_cfg_p1[11:0]);
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.hreadyout <= 1'b1;
      s_q.key <= fsp_pkg::KEY_NONE;
      s_q.fsm <= fsp_pkg::ST_IDLE;
      s_q.cmd <= fsp_pkg::CMD_PROG;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hreadyout;
  assign hresp = s_q.hresp;
  assign cpu_stall = s_q.stall;
  assign nvm_done = s_q.done;
  assign part2_live = s_q.p2_act;
  assign flash_req = s_q.flash_req;
  assign flash_cmd = s_q.cmd;
  assign flash_addr = s_q.flash_addr;
  assign flash_wdata = s_q.flash_wdata;
  assign ram_req = s_q.ram_req;
  assign ram_addr = s_q.ram_addr;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Start bit low whenever idle
  property p_wr_idle;
    s_q.boot_done && s_q.fsm == fsp_pkg::ST_IDLE |-> !s_q.wr;
  endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("start bit high while idle");

  // Start without unlock flags an error and stays idle
  property p_locked_start;
    start_try && s_q.key != fsp_pkg::KEY_OPEN |=> s_q.sequence_error_flag && s_q.fsm == fsp_pkg::ST_IDLE;
  endproperty
  a_locked_start: assert property (p_locked_start) else $error("locked start accepted");

  // Stall only while an operation runs
  property p_stall_busy;
    s_q.stall |-> s_q.fsm != fsp_pkg::ST_IDLE && s_q.wr;
  endproperty
  a_stall_busy: assert property (p_stall_busy) else $error("stall outside operation");

  // Inactive partition erase never stalls
  property p_part_nostall;
    s_q.flash_req && s_q.cmd == fsp_pkg::CMD_ERASE_PART |-> !s_q.stall;
  endproperty
  a_part_nostall: assert property (p_part_nostall) else $error("partition erase stalls");

  // Protected mode in dual mode never touches partition 1
  property p_protect;
    s_q.flash_req && protect_mode && dual_mode |-> s_q.flash_addr[`FSP_PART_BIT];
  endproperty
  a_protect: assert property (p_protect) else $error("protected partition targeted");

  // Programming lands on double-word boundaries
  property p_dword_align;
    s_q.flash_req && s_q.cmd == fsp_pkg::CMD_PROG |-> s_q.flash_addr[1:0] == 2'h0;
  endproperty
  a_dword_align: assert property (p_dword_align) else $error("program misaligned");

  // Page erase lands on page boundaries
  property p_page_align;
    s_q.flash_req && s_q.cmd == fsp_pkg::CMD_ERASE_PAGE |-> s_q.flash_addr[9:0] == 10'h000;
  endproperty
  a_page_align: assert property (p_page_align) else $error("page erase misaligned");

  // Completion pulse follows an acknowledged final step and lasts one cycle
  property p_done_pulse;
    s_q.done |-> $past(flash_ack) ##1 !s_q.done && !s_q.wr;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("bad completion pulse");

  // Unlocked idle swap flips the live partition and sets the flag
  property p_swap;
    swap_exec && dual_mode && s_q.boot_done && s_q.key == fsp_pkg::KEY_OPEN &&
    s_q.fsm == fsp_pkg::ST_IDLE |=> s_q.swp_done && s_q.p2_act != $past(s_q.p2_act);
  endproperty
  a_swap: assert property (p_swap) else $error("swap not performed");

  // Locked swap leaves the partition alone
  property p_swap_nop;
    swap_exec && s_q.boot_done && s_q.key != fsp_pkg::KEY_OPEN |=> $stable(s_q.p2_act);
  endproperty
  a_swap_nop: assert property (p_swap_nop) else $error("locked swap changed partition");

endmodule

// ---- test/fsp_flash_ram_model.sv ----
// Far-side model of the sequencer: flash array answering steps, RAM answering fetches.
// Assumes the sequencer holds each request level until the matching one-cycle answer.
`timescale 1ns/1ns

module fsp_flash_ram_model
#(
  parameter int FLASH_WAIT = 3,
  parameter int RAM_WAIT = 1
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Flash array
  input wire logic flash_req,
  output logic flash_ack,
  // RAM fetch port
  input wire logic ram_req,
  input wire logic [15:0] ram_addr,
  output logic [15:0] ram_rdata,
  output logic ram_valid,
  // Bench control: stop answering RAM fetches
  input wire logic starve
);
  int fwait_q;
  int rwait_q;

  // Flash step finishes after a fixed wait, one ack per request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flash_ack <= 1'b0;
      fwait_q <= 0;
    end
    else
    begin
      flash_ack <= 1'b0;
      if (flash_req && !flash_ack)
      begin
        fwait_q <= (fwait_q == FLASH_WAIT) ? 0 : fwait_q + 1;
        flash_ack <= (fwait_q == FLASH_WAIT);
      end
    end
  end

  // RAM word returned with valid; between answers the data bus toggles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ram_valid <= 1'b0;
      ram_rdata <= 16'h0000;
      rwait_q <= 0;
    end
    else
    begin
      ram_valid <= 1'b0;
      ram_rdata <= ~ram_rdata;
      if (ram_req && !ram_valid && !starve)
      begin
        rwait_q <= (rwait_q == RAM_WAIT) ? 0 : rwait_q + 1;
        if (rwait_q == RAM_WAIT)
        begin
          ram_valid <= 1'b1;
          ram_rdata <= ram_addr ^ 16'h5A3C;
        end
      end
    end
  end
endmodule

// ---- test/test_flash_self_program_dual_partition.sv ----
// Self-checking bench of the flash self-programming sequencer over AHB-Lite.
// Assumes the far-side model answers flash and RAM requests; one clock of 125 MHz.
`timescale 1ns/1ns
`include "fsp_consts.svh"

module test_flash_self_program_dual_partition;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, flash_cmd, fcmd;
  logic [2:0] hsize;
  logic dual_mode, protect_mode, swap_exec, starve, cpu_stall, nvm_done, part2_live;
  logic [23:0] boot_cfg_p1, boot_cfg_p2, flash_addr, faddr;
  logic [47:0] flash_wdata, fwd;
  logic flash_req, flash_ack, fstall, ram_req, ram_valid;
  logic [15:0] ram_addr, ram_rdata;
  logic [48:0] boot_rows [0:4];
  int err_count, comparisons, fcnt, dcnt, i, ftot, dtot, fbase, dbase;

  fsp_sequencer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dual_mode(dual_mode),
    .protect_mode(protect_mode), .boot_cfg_p1(boot_cfg_p1), .boot_cfg_p2(boot_cfg_p2),
    .swap_exec(swap_exec), .cpu_stall(cpu_stall), .nvm_done(nvm_done),
    .part2_live(part2_live), .flash_req(flash_req), .flash_cmd(flash_cmd),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_ack(flash_ack),
    .ram_req(ram_req), .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_valid(ram_valid));

  fsp_flash_ram_model partner (.hclk(hclk), .hresetn(hresetn), .flash_req(flash_req),
    .flash_ack(flash_ack), .ram_req(ram_req), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .ram_valid(ram_valid), .starve(starve));

  // Clock of 8 ns
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Steps and pulses counted since the current scenario began
  assign fcnt = ftot - fbase;
  assign dcnt = dtot - dbase;

  // Record flash steps and completion pulses
  always @(posedge hclk)
  begin
    if (flash_req === 1'b1 && flash_ack === 1'b1)
    begin
      if (fcnt == 0)
        fwd <= flash_wdata;
      ftot <= ftot + 1;
      faddr <= flash_addr;
      fcmd <= flash_cmd;
      fstall <= cpu_stall;
    end
    if (nvm_done === 1'b1)
      dtot <= dtot + 1;
  end

  task test_done;
    $display("counts: %0d mismatches, %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task give_up(input string what);
    err_count++;
    $display("[FAIL] %0t timeout waiting for %s", $time, what);
    test_done();
  endtask

  task chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Hold the current phase until ready is seen at a rising edge
  task wait_ready;
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
        give_up("bus ready");
      @(negedge hclk);
    end
    rdv = hrdata;
    @(posedge hclk);
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task unlock;
    wr(`FSP_OFS_KEY, {24'h000000, `FSP_KEY_FIRST});
    wr(`FSP_OFS_KEY, {24'h000000, `FSP_KEY_SECOND});
  endtask

  // Start an operation, then poll the control word until the start bit drops
  task run(input logic [15:0] ctl, input logic key);
    int n;
    fbase = ftot;
    dbase = dtot;
    n = 0;
    if (key)
      unlock();
    wr(`FSP_OFS_CTRL, {16'h0000, ctl});
    bus(1'b0, `FSP_OFS_CTRL, 32'h00000000);
    while (rdv[15] !== 1'b0)
    begin
      n++;
      if (n > 900)
        give_up("operation end");
      bus(1'b0, `FSP_OFS_CTRL, 32'h00000000);
    end
  endtask

  task do_reset;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  // First instruction pair of a row as fetched from RAM at s
  function automatic logic [47:0] pair(input logic [15:0] s, input logic pk);
    logic [15:0] w0, w1, w2, w3;
    w0 = s ^ 16'h5A3C;
    w1 = (s + 16'h0002) ^ 16'h5A3C;
    w2 = (s + 16'h0004) ^ 16'h5A3C;
    w3 = (s + 16'h0006) ^ 16'h5A3C;
    return pk ? {w1[15:8], w2, w1[7:0], w0} : {w3[7:0], w2, w1[7:0], w0};
  endfunction

  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, swap_exec, starve, protect_mode} = 6'h00;
    dual_mode = 1'b1;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    boot_cfg_p1 = 24'h000000;
    boot_cfg_p2 = 24'h000000;
    {err_count, comparisons, fbase, dbase} = {32'h0, 32'h0, 32'h0, 32'h0};
    boot_rows = '{{24'hFFA005, 24'hFFC003, 1'b1}, {24'hFFD002, 24'hFF8007, 1'b0},
      {24'h000005, 24'hFF6009, 1'b1}, {24'hFF6009, 24'h000005, 1'b0},
      {24'h000005, 24'h000009, 1'b0}};
    // Boot partition choice and reset contents of the control word
    for (i = 0; i < 5; i++)
    begin
      @(posedge hclk);
      boot_cfg_p1 <= boot_rows[i][48:25];
      boot_cfg_p2 <= boot_rows[i][24:1];
      do_reset();
      @(negedge hclk);
      chk(part2_live, boot_rows[i][0], "live partition after reset");
      bus(1'b0, `FSP_OFS_CTRL, 32'h00000000);
      chk({hresp, rdv}, {1'b0, 21'h0, boot_rows[i][0], 10'h0}, "control after reset");
      $display("boot case %0d done", i);
    end
    // Start without key is refused
    run(16'hC003, 1'b0);
    chk(rdv[13], 1'b1, "error without key");
    chk(fcnt, 0, "no flash step without key");
    wr(`FSP_OFS_CTRL, 32'h00000000);
    // Page erase on the running region
    wr(`FSP_OFS_ADRL, 32'h00001234);
    wr(`FSP_OFS_ADRH, 32'h00000000);
    run(16'hC003, 1'b1);
    chk(faddr, 24'h001000, "page aligned");
    chk(fcmd, fsp_pkg::CMD_ERASE_PAGE, "page erase command");
    chk(fstall, 1'b1, "stall on running region");
    chk(dcnt, 1, "completion pulse");
    $display("page erase done");
    // Whole inactive partition erase before programming it
    run(16'hC004, 1'b1);
    chk(fcmd, fsp_pkg::CMD_ERASE_PART, "partition erase command");
    chk({fstall, dcnt[0]}, 2'h1, "partition erase no stall");
    // Double word on the inactive partition
    wr(`FSP_OFS_LAT0, 32'h00123456);
    wr(`FSP_OFS_LAT1, 32'h00654321);
    wr(`FSP_OFS_ADRL, 32'h00000006);
    wr(`FSP_OFS_ADRH, 32'h00000040);
    run(16'hC001, 1'b1);
    chk(faddr, 24'h400004, "double word address");
    chk(fwd, 48'h654321123456, "double word data");
    chk({fstall, fcmd}, 3'h0, "inactive program no stall");
    $display("double word done");
    // Row program unpacked, with an operation change tried while busy
    wr(`FSP_OFS_SRC, 32'h00000100);
    wr(`FSP_OFS_ADRL, 32'h00000085);
    fbase = ftot;
    unlock();
    wr(`FSP_OFS_CTRL, 32'h0000C002);
    wr(`FSP_OFS_CTRL, 32'h0000C003);
    bus(1'b0, `FSP_OFS_CTRL, 32'h00000000);
    chk(rdv[15:0], 16'hC002, "operation kept while busy");
    run(16'hC002, 1'b0);
    chk(fcnt, 32, "row steps");
    chk(faddr, 24'h4000FC, "last pair address");
    chk(fwd, pair(16'h0100, 1'b0), "unpacked pair");
    // Row program packed
    wr(`FSP_OFS_SRC, 32'h00000200);
    run(16'hC202, 1'b1);
    chk(fwd, pair(16'h0200, 1'b1), "packed pair");
    chk({fcnt[15:0], dcnt[15:0]}, {16'h0020, 16'h0001}, "packed row steps");
    $display("row program done");
    // Reserved operation codes
    foreach (boot_rows[i])
    begin
      run({12'hC00, (i == 0) ? 4'h0 : (i == 1) ? 4'h5 : 4'hF}, 1'b1);
      chk({rdv[13], fcnt[0]}, 2'h2, "reserved code refused");
      wr(`FSP_OFS_CTRL, 32'h00000000);
    end
    // Fetch underrun ends the row without completion
    @(posedge hclk);
    starve <= 1'b1;
    run(16'hC002, 1'b1);
    chk({rdv[8], dcnt[0]}, 2'h2, "underrun");
    starve <= 1'b0;
    wr(`FSP_OFS_CTRL, 32'h00000000);
    // Broken unlock: other write between keys, then a wrong second key
    wr(`FSP_OFS_KEY, 32'h00000055);
    wr(`FSP_OFS_SRC, 32'h00000100);
    wr(`FSP_OFS_KEY, 32'h000000AA);
    run(16'hC001, 1'b0);
    chk({rdv[13], fcnt[0]}, 2'h2, "unlock broken by write");
    wr(`FSP_OFS_KEY, 32'h00000055);
    wr(`FSP_OFS_KEY, 32'h0000005A);
    run(16'hC001, 1'b0);
    chk({rdv[13], fcnt[0]}, 2'h2, "wrong second key");
    wr(`FSP_OFS_CTRL, 32'h00000000);
    // Protected mode refuses erase of partition 1
    @(posedge hclk);
    protect_mode <= 1'b1;
    wr(`FSP_OFS_ADRH, 32'h00000000);
    run(16'hC003, 1'b1);
    chk({rdv[13], fcnt[0]}, 2'h2, "partition 1 protected");
    run(16'hC004, 1'b1);
    chk({rdv[13], dcnt[0]}, 2'h1, "partition 2 open when protected");
    protect_mode <= 1'b0;
    dual_mode <= 1'b0;
    run(16'hC004, 1'b1);
    chk({rdv[13], fcnt[0]}, 2'h2, "partition erase needs dual mode");
    dual_mode <= 1'b1;
    wr(`FSP_OFS_CTRL, 32'h00000000);
    $display("refusals done");
    // Swap without key, then with key, then clear the flag
    for (i = 0; i < 2; i++)
    begin
      if (i == 1)
        unlock();
      @(posedge hclk);
      swap_exec <= 1'b1;
      @(posedge hclk);
      swap_exec <= 1'b0;
      repeat (2) @(posedge hclk);
      bus(1'b0, `FSP_OFS_CTRL, 32'h00000000);
      chk({part2_live, rdv[11:10]}, {i[0], i[0], i[0]}, "swap result");
    end
    wr(`FSP_OFS_CTRL, 32'h00000000);
    bus(1'b0, `FSP_OFS_CTRL, 32'h00000000);
    chk(rdv[11:10], 2'h1, "swap flag cleared");
    $display("swap done");
    test_done();
  end
endmodule
